//--- atc_acq_ctrl.sv
// How it works
// - External trigger fires on a software-chosen rising or falling edge.
// - Level trigger: selected channel crossing threshold, up or down.
// - Post-trigger mode: one trigger, then fill the whole active memory.
// - Segmented mode: each segment waits for its own new trigger.
// - Memory full sets a readable flag and, if enabled, an interrupt.
// - Free-run streaming ignores memory size until terminate command.
// - In segmented mode each valid trigger captures segment-size samples, or fewer when memory fills mid-segment.
// - A sample history lets pre-trigger samples be stored.
// - Trigger-delay samples after the trigger are discarded.
// - Timestamp is an unsigned 64-bit count of clock ticks.
// - Leaving standby clears the stamp counter, then it counts each cycle.
// - Stamps go into a FIFO, readable during and after capture, until its 16 entries fill.
// - Segment stamp mode stamps the start of each segment.
// - External-trigger stamp mode stamps each external trigger pulse.
// - Digital-pulse stamp mode stamps each digital I/O pulse.
// - Buffered streaming works with post-trigger or segmented modes.
// - Standby captures and moves nothing; leaving it starts acquisition.
`timescale 1ns/1ps
`default_nettype none
`include "atc_params.svh"
module atc_acq_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire atc_pkg::atc_bus_type bus,
  output logic [31:0] rdata,
  // Event inputs
  input wire logic ext_trig,
  input wire logic dio_pulse,
  input wire atc_pkg::atc_sample_type sample,
  // Sample store, interrupt and busy outputs
  output atc_pkg::atc_store_type store,
  output logic mem_full_irq,
  output logic acq_busy
);
  import atc_pkg::*;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  atc_mode_type mode;
  atc_ts_mode_type ts_mode;
  logic segmented;
  logic free_run;
  logic irq_en;
  logic level_sel;
  logic falling;
  logic chan_sel;
  logic [13:0] level;
  logic [29:0] mem_words;
  logic [29:0] seg_words;
  logic [`ATC_HIST_AW-1:0] pre_count;
  logic [31:0] delay_count;
  logic mem_full;
  logic terminated;

  function automatic logic hit(input logic [7:0] off);
    hit = (bus.addr == off);
  endfunction

  logic wr_cmd;
  logic done_evt;
  assign wr_cmd = bus.wr && hit(`ATC_REG_CMD);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= ATC_STANDBY;
      ts_mode <= ATC_TS_OFF;
      segmented <= 1'b0;
      free_run <= 1'b0;
      irq_en <= 1'b0;
    end else if (bus.wr && hit(`ATC_REG_CTRL)) begin
      mode <= atc_mode_type'(bus.wdata[`ATC_CTRL_MODE_LSB +: 2]);
      segmented <= bus.wdata[`ATC_CTRL_SEGMENTED];
      free_run <= bus.wdata[`ATC_CTRL_FREE_RUN];
      irq_en <= bus.wdata[`ATC_CTRL_IRQ_EN];
      ts_mode <= atc_ts_mode_type'(bus.wdata[`ATC_CTRL_TS_LSB +: 2]);
    end else if (done_evt) begin
      mode <= ATC_STANDBY;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_sel <= 1'b0;
      falling <= 1'b0;
      chan_sel <= 1'b0;
      level <= 14'h0000;
      mem_words <= `ATC_MEMSZ_RESET;
      seg_words <= `ATC_SEGSZ_RESET;
      pre_count <= '0;
      delay_count <= 32'h00000000;
    end else if (bus.wr) begin
      if (hit(`ATC_REG_TRIG)) begin
        level_sel <= bus.wdata[`ATC_TRIG_LEVEL_SEL];
        falling <= bus.wdata[`ATC_TRIG_FALLING];
        chan_sel <= bus.wdata[`ATC_TRIG_CHAN];
      end
      if (hit(`ATC_REG_LEVEL)) level <= bus.wdata[13:0];
      // Size in bytes; the low three bits fall away as 8-byte steps
      if (hit(`ATC_REG_MEMSZ)) mem_words <= bus.wdata[31:2] >> 1;
      if (hit(`ATC_REG_SEGSZ)) seg_words <= bus.wdata[29:0];
      if (hit(`ATC_REG_PRE)) pre_count <= bus.wdata[`ATC_HIST_AW-1:0];
      if (hit(`ATC_REG_DELAY)) delay_count <= bus.wdata;
    end
  end

  // ------------------------------------------------------------
  // Trigger detection
  // ------------------------------------------------------------
  logic ext_prev;
  logic above_prev;
  logic dio_prev;
  logic [13:0] chan_val;
  logic above;
  logic ext_edge;
  logic lvl_edge;
  logic trig_evt;
  logic ext_pulse;
  logic dio_evt;
  assign chan_val = chan_sel ? sample.ch1 : sample.ch0;
  assign above = chan_val >= level;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev <= 1'b0;
      dio_prev <= 1'b0;
      above_prev <= 1'b0;
    end else begin
      ext_prev <= ext_trig;
      dio_prev <= dio_pulse;
      if (sample.valid) above_prev <= above;
    end
  end
  assign ext_pulse = ext_trig && !ext_prev;
  assign ext_edge = falling ? (!ext_trig && ext_prev) : ext_pulse;
  assign lvl_edge = sample.valid &&
                    (falling ? (!above && above_prev)
                             : (above && !above_prev));
  assign dio_evt = dio_pulse && !dio_prev;
  assign trig_evt = level_sel ? lvl_edge : ext_edge;

  // ------------------------------------------------------------
  // Acquisition sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ATC_IDLE = 2'b00,
    ATC_ARMED = 2'b01,
    ATC_DELAY = 2'b10,
    ATC_CAPTURE = 2'b11
  } atc_seq_type;
  atc_seq_type seq;
  atc_mode_type mode_prev;
  logic start_evt;
  logic running;
  logic [31:0] delay_left;
  logic [29:0] seg_left;
  logic [29:0] mem_left;
  logic [`ATC_HIST_AW-1:0] lag;
  logic take;
  logic last_word;
  logic seg_start;
  logic [27:0] hist_out;

  assign running = (mode != ATC_STANDBY);
  assign start_evt = running && (mode_prev == ATC_STANDBY);
  assign take = (seq == ATC_CAPTURE) && sample.valid;
  assign last_word = take && !free_run && (mem_left == 30'h00000001);
  assign done_evt = last_word || (wr_cmd && bus.wdata[`ATC_CMD_TERMINATE]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_prev <= ATC_STANDBY;
    end else begin
      mode_prev <= mode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq <= ATC_IDLE;
      delay_left <= 32'h00000000;
      seg_left <= 30'h00000000;
      mem_left <= 30'h00000000;
      lag <= '0;
      seg_start <= 1'b0;
    end else begin
      seg_start <= 1'b0;
      unique case (seq)
        ATC_IDLE: begin
          if (start_evt) begin
            seq <= ATC_ARMED;
            mem_left <= mem_words;
          end
        end
        ATC_ARMED: begin
          // Only armed state listens, so captures are never re-triggered
          if (!running) begin
            seq <= ATC_IDLE;
          end else if (trig_evt) begin
            seg_left <= seg_words;
            seg_start <= 1'b1;
            lag <= pre_count;
            delay_left <= delay_count;
            seq <= (delay_count == 32'h00000000) ? ATC_CAPTURE
                                                 : ATC_DELAY;
          end
        end
        ATC_DELAY: begin
          if (!running) begin
            seq <= ATC_IDLE;
          end else if (sample.valid) begin
            delay_left <= delay_left - 32'h00000001;
            if (delay_left == 32'h00000001) seq <= ATC_CAPTURE;
          end
        end
        ATC_CAPTURE: begin
          if (!running || done_evt) begin
            seq <= ATC_IDLE;
          end else if (take) begin
            mem_left <= mem_left - 30'h00000001;
            seg_left <= seg_left - 30'h00000001;
            // Segments end back in armed; post-trigger runs to the end
            if (segmented && seg_left == 30'h00000001) begin
              seq <= ATC_ARMED;
            end
          end
        end
      endcase
    end
  end

  atc_history u_history (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(sample.valid),
    .din({sample.ch0, sample.ch1}),
    .lag(lag),
    .dout(hist_out)
  );

  // Same path for RAM and buffered streaming modes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      store <= '0;
      acq_busy <= 1'b0;
    end else begin
      store.valid <= take;
      store.data <= hist_out;
      acq_busy <= running;
    end
  end

  // ------------------------------------------------------------
  // Memory full flag
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_full <= 1'b0;
      terminated <= 1'b0;
    end else begin
      if (last_word) begin
        mem_full <= 1'b1;
      end else if (wr_cmd && bus.wdata[`ATC_CMD_CLR_FULL]) begin
        mem_full <= 1'b0;
      end
      if (done_evt && !last_word) terminated <= 1'b1;
      else if (start_evt) terminated <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_full_irq <= 1'b0;
    end else begin
      mem_full_irq <= irq_en && (mem_full || last_word);
    end
  end

  // ------------------------------------------------------------
  // Timestamps
  // ------------------------------------------------------------
  logic [63:0] ts_cnt;
  logic ts_push;
  logic ts_pop;
  logic [63:0] ts_head;
  logic [`ATC_TS_AW:0] ts_count;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_cnt <= 64'h0000000000000000;
    end else if (start_evt) begin
      ts_cnt <= 64'h0000000000000000;
    end else if (running) begin
      ts_cnt <= ts_cnt + 64'h0000000000000001;
    end
  end
  always_comb begin
    ts_push = 1'b0;
    if (running) begin
      unique case (ts_mode)
        ATC_TS_OFF: ts_push = 1'b0;
        ATC_TS_SEGMENT: ts_push = seg_start && segmented;
        ATC_TS_EXT_TRIG: ts_push = ext_pulse;
        ATC_TS_DIO: ts_push = dio_evt;
      endcase
    end
  end
  assign ts_pop = wr_cmd && bus.wdata[`ATC_CMD_TS_POP];

  atc_ts_fifo u_ts_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(ts_push),
    .din(ts_cnt),
    .pop(ts_pop),
    .flush(start_evt),
    .dout(ts_head),
    .count(ts_count)
  );

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h00000000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `ATC_REG_CTRL: rdata <= {25'h0000000, ts_mode, irq_en, free_run,
                                 segmented, mode};
        `ATC_REG_TRIG: rdata <= {29'h00000000, chan_sel, falling, level_sel};
        `ATC_REG_LEVEL: rdata <= {18'h00000, level};
        `ATC_REG_MEMSZ: rdata <= {mem_words[28:0], 3'h0};
        `ATC_REG_SEGSZ: rdata <= {2'h0, seg_words};
        `ATC_REG_PRE: rdata <= {28'h0000000, pre_count};
        `ATC_REG_DELAY: rdata <= delay_count;
        `ATC_REG_STATUS: rdata <= {25'h0000000, terminated, seq, running,
                                   mem_full, ts_count != '0, acq_busy};
        `ATC_REG_TS_LO: rdata <= ts_head[31:0];
        `ATC_REG_TS_HI: rdata <= ts_head[63:32];
        `ATC_REG_TSCNT: rdata <= {27'h0000000, ts_count};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- atc_acq_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_params.svh"
module atc_acq_ctrl_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched ports
  input wire atc_pkg::atc_bus_type bus,
  input wire logic [31:0] rdata,
  input wire atc_pkg::atc_sample_type sample,
  input wire atc_pkg::atc_store_type store,
  input wire logic mem_full_irq,
  input wire logic acq_busy
);
  import atc_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------
  store_in_busy_a:
    assert property (store.valid |-> acq_busy)
    else $error("store pulse while in standby");
  store_per_sample_a:
    assert property (store.valid |-> $past(sample.valid))
    else $error("store pulse without an input sample");
  start_quiet_a:
    assert property ($rose(acq_busy) |-> (!store.valid) [*2])
    else $error("store pulse before the trigger could arm");
  busy_start_a:
    assert property ($rose(acq_busy) |->
      $past(bus.wr) || $past(bus.wr, 2) || $past(bus.wr, 3))
    else $error("acquisition started without a register write");
  irq_cause_a:
    // A control write shows on the interrupt two edges later
    assert property ($rose(mem_full_irq) |->
      $past(acq_busy) || $past(bus.wr, 2))
    else $error("interrupt rose without a fill or a write");
  irq_idle_a:
    // Busy still stands in the first interrupt cycle
    assert property ($rose(mem_full_irq) |=> !acq_busy)
    else $error("interrupt raised while still acquiring");
  status_busy_a:
    assert property ($past(bus.rd) && $past(bus.addr) == `ATC_REG_STATUS
      |-> rdata[0] == $past(acq_busy))
    else $error("status busy bit disagrees with busy output");
  ts_fill_a:
    assert property ($past(bus.rd) && $past(bus.addr) == `ATC_REG_TSCNT
      |-> rdata <= 32'h10)
    else $error("stamp count above the fifo depth");
endmodule
bind atc_acq_ctrl atc_acq_ctrl_sva sva_i (.ref_clk(ref_clk), .rst_b(rst_b),
  .bus(bus), .rdata(rdata), .sample(sample), .store(store),
  .mem_full_irq(mem_full_irq), .acq_busy(acq_busy));
`default_nettype wire

//--- atc_acq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_params.svh"
module atc_acq_ctrl_tb;
  import atc_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, slow = 1'b0, fire = 1'b0;
  logic dio_fire = 1'b0, ext_trig, dio_pulse, mem_full_irq, acq_busy;
  logic [3:0] hold = 4'h0;
  atc_bus_type bus = '0;
  atc_sample_type sample;
  atc_store_type store;
  logic [31:0] rdata, v;
  logic [27:0] first;
  logic [13:0] t0, k0, lvl;
  logic [63:0] s1, s2;
  int n_errors = 0, n_tests = 0, n_st = 0, cyc = 0, c1, ca, cb, cs;
  atc_acq_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .ext_trig(ext_trig), .dio_pulse(dio_pulse),
    .sample(sample), .store(store), .mem_full_irq(mem_full_irq),
    .acq_busy(acq_busy));
  atc_src src (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .fire(fire),
    .hold(hold), .dio_fire(dio_fire), .ext_trig(ext_trig),
    .dio_pulse(dio_pulse), .sample(sample));
  always #5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------
  // Store counter and run ceiling
  // ----------------------------------------------------------
  // Ceiling sits far above the several hundred cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (store.valid === 1'b1) begin
      if (n_st == 0) first <= store.data;
      n_st <= n_st + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task conclude();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task pop(output logic [63:0] t);
    logic [31:0] lo, hi;
    rd(`ATC_REG_TS_LO, lo);
    rd(`ATC_REG_TS_HI, hi);
    wr(`ATC_REG_CMD, 32'h4);
    t = {hi, lo};
  endtask
  task pulse(input logic d, input logic [3:0] h);
    @(posedge ref_clk);
    hold <= h;
    if (d) dio_fire <= 1'b1;
    else fire <= 1'b1;
    #1 t0 = sample.ch0;
    c1 = cyc;
    @(posedge ref_clk);
    fire <= 1'b0;
    dio_fire <= 1'b0;
  endtask
  task idle();
    for (int i = 0; i < 500 && acq_busy !== 1'b0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask
  task cap(input logic [31:0] ctrl, input logic [3:0] h, input logic ext);
    n_st = 0;
    wr(`ATC_REG_CTRL, ctrl);
    repeat (8) @(posedge ref_clk);
    if (ext) pulse(1'b0, h);
    idle();
  endtask
  function logic [13:0] off();
    return first[27:14] - t0;
  endfunction
  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    pulse(1'b0, 4'h0);
    repeat (8) @(posedge ref_clk);
    chk(n_st, 0);
    rd(`ATC_REG_STATUS, v);
    chk(v[0], 1'b0);
    wr(`ATC_REG_MEMSZ, 32'h28);
    rd(`ATC_REG_MEMSZ, v);
    chk(v, 32'h28);
    wr(`ATC_REG_TRIG, 32'h0);
    cap(32'h51, 4'h0, 1'b1);
    k0 = off();
    chk(n_st, 5);
    chk(mem_full_irq, 1'b1);
    rd(`ATC_REG_STATUS, v);
    chk(v[2], 1'b1);
    rd(`ATC_REG_TSCNT, v);
    chk(v, 32'h1);
    wr(`ATC_REG_CMD, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(mem_full_irq, 1'b0);
    wr(`ATC_REG_PRE, 32'h3);
    cap(32'h01, 4'h0, 1'b1);
    chk(off(), 14'(k0 - 14'h3));
    wr(`ATC_REG_PRE, 32'h0);
    wr(`ATC_REG_DELAY, 32'h4);
    cap(32'h01, 4'h0, 1'b1);
    chk(off(), 14'(k0 + 14'h4));
    wr(`ATC_REG_DELAY, 32'h0);
    wr(`ATC_REG_TRIG, 32'h2);
    cap(32'h01, 4'h5, 1'b1);
    chk(off(), 14'(k0 + 14'h6));
    // Up on channel 0, down on channel 1
    for (int j = 0; j < 2; j++) begin
      #1 lvl = j ? sample.ch1 - 14'h3C : sample.ch0 + 14'h3C;
      wr(`ATC_REG_LEVEL, {18'h0, lvl});
      wr(`ATC_REG_TRIG, j ? 32'h7 : 32'h1);
      cap(32'h01, 4'h0, 1'b0);
      chk(n_st, 5);
      t0 = j ? lvl - first[13:0] : first[27:14] - lvl;
      chk(t0 <= 14'h8, 1'b1);
    end
    wr(`ATC_REG_TRIG, 32'h0);
    wr(`ATC_REG_MEMSZ, 32'h80);
    wr(`ATC_REG_SEGSZ, 32'h8);
    // Second trigger lands inside segment one and must be ignored
    n_st = 0;
    wr(`ATC_REG_CTRL, 32'h25);
    repeat (8) @(posedge ref_clk);
    pulse(1'b0, 4'h0);
    ca = c1;
    pulse(1'b0, 4'h0);
    repeat (20) @(posedge ref_clk);
    chk(n_st <= 8, 1'b1);
    chk(n_st, 8);
    chk(acq_busy, 1'b1);
    pulse(1'b0, 4'h0);
    cb = c1;
    idle();
    chk(n_st, 16);
    rd(`ATC_REG_TSCNT, v);
    chk(v, 32'h2);
    pop(s1);
    pop(s2);
    chk(s2 - s1, 64'(cb - ca));
    wr(`ATC_REG_MEMSZ, 32'h2000);
    wr(`ATC_REG_CTRL, 32'h61);
    #1 cs = cyc;
    repeat (12) @(posedge ref_clk);
    pulse(1'b1, 4'h0);
    ca = c1;
    repeat (9) @(posedge ref_clk);
    pulse(1'b1, 4'h0);
    cb = c1;
    pop(s1);
    pop(s2);
    chk(s2 - s1, 64'(cb - ca));
    chk(s1[63:32], 32'h0);
    chk(s1 + 64'h4 >= 64'(ca - cs) && s1 <= 64'(ca - cs + 4), 1'b1);
    wr(`ATC_REG_CMD, 32'h1);
    idle();
    wr(`ATC_REG_MEMSZ, 32'h8);
    slow <= 1'b1;
    n_st = 0;
    wr(`ATC_REG_CTRL, 32'h0A);
    repeat (8) @(posedge ref_clk);
    pulse(1'b0, 4'h0);
    repeat (30) @(posedge ref_clk);
    chk(n_st > 4, 1'b1);
    chk(acq_busy, 1'b1);
    wr(`ATC_REG_CMD, 32'h1);
    idle();
    rd(`ATC_REG_STATUS, v);
    chk(v[6], 1'b1);
    chk(v[0], 1'b0);
    conclude();
  end
endmodule
`default_nettype wire

//--- atc_history.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_params.svh"
module atc_history (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Sample input and readback delay
  input wire logic push,
  input wire logic [27:0] din,
  input wire logic [`ATC_HIST_AW-1:0] lag,
  // Delayed sample
  output logic [27:0] dout
);
  import atc_pkg::*;
  logic [27:0] mem [`ATC_HIST_DEPTH];
  logic [`ATC_HIST_AW-1:0] wptr;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= '0;
    end else if (push) begin
      wptr <= wptr + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr] <= din;
    end
  end
  // Lag 0 is the live sample; the window is limited to the depth
  assign dout = (lag == '0) ? din : mem[wptr - lag];
endmodule
`default_nettype wire

//--- atc_params.svh
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ATC_REG_CTRL 8'h00
`define ATC_REG_TRIG 8'h04
`define ATC_REG_LEVEL 8'h08
`define ATC_REG_MEMSZ 8'h0C
`define ATC_REG_SEGSZ 8'h10
`define ATC_REG_PRE 8'h14
`define ATC_REG_DELAY 8'h18
`define ATC_REG_STATUS 8'h1C
`define ATC_REG_TS_LO 8'h20
`define ATC_REG_TS_HI 8'h24
`define ATC_REG_TSCNT 8'h28
`define ATC_REG_CMD 8'h2C
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ATC_CTRL_MODE_LSB 0
`define ATC_CTRL_SEGMENTED 2
`define ATC_CTRL_FREE_RUN 3
`define ATC_CTRL_IRQ_EN 4
`define ATC_CTRL_TS_LSB 5
`define ATC_TRIG_LEVEL_SEL 0
`define ATC_TRIG_FALLING 1
`define ATC_TRIG_CHAN 2
`define ATC_CMD_TERMINATE 0
`define ATC_CMD_CLR_FULL 1
`define ATC_CMD_TS_POP 2
// ------------------------------------------------------------
// Sizes and reset values
// ------------------------------------------------------------
`define ATC_HIST_DEPTH 16
`define ATC_HIST_AW 4
`define ATC_TS_DEPTH 16
`define ATC_TS_AW 4
`define ATC_BYTES_PER_WORD 8
`define ATC_MEMSZ_RESET 30'h00000001
`define ATC_SEGSZ_RESET 30'h00000001
`endif

//--- atc_pkg.sv
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_STANDBY = 2'b00,
    ATC_RAM_ACQ = 2'b01,
    ATC_BUF_ACQ = 2'b10,
    ATC_SP_ACQ = 2'b11
  } atc_mode_type;
  typedef enum logic [1:0] {
    ATC_TS_OFF = 2'b00,
    ATC_TS_SEGMENT = 2'b01,
    ATC_TS_EXT_TRIG = 2'b10,
    ATC_TS_DIO = 2'b11
  } atc_ts_mode_type;
  typedef struct packed {
    logic valid;
    logic [13:0] ch0;
    logic [13:0] ch1;
  } atc_sample_type;
  typedef struct packed {
    logic valid;
    logic [27:0] data;
  } atc_store_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atc_bus_type;
endpackage

//--- atc_src.sv
`timescale 1ns/1ps
`default_nettype none
module atc_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bench requests
  input wire logic slow,
  input wire logic fire,
  input wire logic [3:0] hold,
  input wire logic dio_fire,
  // Far-side lines
  output logic ext_trig,
  output logic dio_pulse,
  output atc_pkg::atc_sample_type sample
);
  import atc_pkg::*;
  logic [13:0] ramp;
  logic [3:0] left;
  logic odd;
  // ----------------------------------------------------------
  // Sample ramp and trigger pulses
  // ----------------------------------------------------------
  // A ramp lets every stored word tell when it was sampled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp <= 14'h0;
      odd <= 1'b0;
      sample <= '0;
    end else begin
      odd <= ~odd;
      sample.valid <= !slow || odd;
      sample.ch0 <= ramp;
      sample.ch1 <= ~ramp;
      if (!slow || odd) begin
        ramp <= ramp + 14'h1;
      end
    end
  end
  // Pulse stays high hold+1 cycles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_trig <= 1'b0;
      left <= 4'h0;
      dio_pulse <= 1'b0;
    end else begin
      dio_pulse <= dio_fire;
      if (fire) begin
        ext_trig <= 1'b1;
        left <= hold;
      end else if (left != 4'h0) begin
        left <= left - 4'h1;
      end else begin
        ext_trig <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- atc_ts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "atc_params.svh"
module atc_ts_fifo (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic push,
  input wire logic [63:0] din,
  // Drain side
  input wire logic pop,
  input wire logic flush,
  output logic [63:0] dout,
  output logic [`ATC_TS_AW:0] count
);
  import atc_pkg::*;
  logic [63:0] mem [`ATC_TS_DEPTH];
  logic [`ATC_TS_AW-1:0] wptr;
  logic [`ATC_TS_AW-1:0] rptr;
  logic do_push;
  logic do_pop;
  // A full FIFO drops new stamps rather than overwrite unread ones
  assign do_push = push && (count != `ATC_TS_DEPTH);
  assign do_pop = pop && (count != '0);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else if (flush) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wptr <= wptr + 1'b1;
      if (do_pop) rptr <= rptr + 1'b1;
      if (do_push && !do_pop) count <= count + 1'b1;
      else if (do_pop && !do_push) count <= count - 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (do_push) mem[wptr] <= din;
  end
  assign dout = mem[rptr];
endmodule
`default_nettype wire
